// [rtl/bit_sync.sv]
// Two flip-flop synchroniser for a group of independent levels
`timescale 1ns/1ps
module bit_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_en,
    input  wire logic [WIDTH-1:0] i_d,
    output logic      [WIDTH-1:0] o_q
);
    logic [WIDTH-1:0] stage1;

    // Stage one feeds stage two only
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            stage1 <= '0;
            o_q    <= '0;
        end else if (i_en) begin
            stage1 <= i_d;
            o_q    <= stage1;
        end
    end
endmodule

// [rtl/flash_array_write_protect.sv]
// Status word protection logic: range decode, lock modes, one-time bits
`timescale 1ns/1ps
module flash_array_write_protect (
    input  wire logic        i_clk_sys,
    input  wire logic        i_sys_rst,
    input  wire logic        i_clk_en,
    input  wire logic        i_spi_clk,
    input  wire logic        i_cmd_valid,
    input  wire logic [7:0]  i_cmd_code,
    input  wire logic [23:0] i_cmd_addr,
    input  wire logic [15:0] i_cmd_data,
    input  wire logic        i_write_guard,
    input  wire logic        i_array_busy,
    input  wire logic [15:0] i_nv_word,
    output logic             o_cmd_ready,
    output logic      [15:0] o_status_word,
    output logic             o_array_go,
    output logic             o_array_refuse,
    output logic      [23:0] o_array_addr,
    output logic      [7:0]  o_array_code,
    output logic             o_sreg_refuse,
    output logic             o_nv_store,
    output logic      [15:0] o_nv_word,
    output logic      [3:0]  o_otp_lock,
    output logic             o_four_lane_enable,
    output logic             o_guard_pin_enable,
    output logic             o_pause_pin_enable
);
    // ****************************************
    // Link side: command capture and status return
    // ****************************************
    logic        req_tgl;
    logic [7:0]  link_code;
    logic [23:0] link_addr;
    logic [15:0] link_data;
    logic        ack_link_sync;
    logic        ack_seen;
    logic        ack_tgl;
    logic [15:0] status_copy;
    wire         cmd_take;

    // A new command waits until the previous status snapshot has come back
    assign o_cmd_ready = (req_tgl == ack_seen);
    assign cmd_take    = i_cmd_valid & o_cmd_ready;

    // Held words stay stable until the acknowledge returns
    always_ff @(posedge i_spi_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            req_tgl   <= 1'b0;
            link_code <= 8'h00;
            link_addr <= 24'h000000;
            link_data <= 16'h0000;
        end else if (cmd_take) begin
            req_tgl   <= ~req_tgl;
            link_code <= i_cmd_code;
            link_addr <= i_cmd_addr;
            link_data <= i_cmd_data;
        end
    end

    bit_sync #(.WIDTH(1)) u_ack_sync (
        .i_clk (i_spi_clk),
        .i_rst (i_sys_rst),
        .i_en  (1'b1),
        .i_d   (ack_tgl),
        .o_q   (ack_link_sync)
    );

    always_ff @(posedge i_spi_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ack_seen      <= 1'b0;
            o_status_word <= fwp_pkg::STATUS_RESET;
        end else if (ack_link_sync != ack_seen) begin
            ack_seen      <= ack_link_sync;
            o_status_word <= status_copy;
        end
    end

    // ****************************************
    // System side: synchronisers and decode
    // ****************************************
    logic [1:0] sys_sync_q;
    wire        req_sync;
    wire        guard_sync;

    bit_sync #(.WIDTH(2)) u_sys_sync (
        .i_clk (i_clk_sys),
        .i_rst (i_sys_rst),
        .i_en  (i_clk_en),
        .i_d   ({i_write_guard, req_tgl}),
        .o_q   (sys_sync_q)
    );
    assign req_sync   = sys_sync_q[0];
    assign guard_sync = sys_sync_q[1];

    logic       nv_loaded;
    logic [2:0] range_code;
    logic       top_bottom_select;
    logic       small_unit_select;
    logic       invert_protect;
    logic [1:0] lock_mode;
    logic       four_lane_enable;
    logic [3:0] otp_lock_bits;
    logic       write_enable_latch;
    logic       paused_flag;
    logic       req_seen;
    logic       ack_pending;

    wire proc;
    wire is_wren;
    wire is_wrdi;
    wire is_wrsr;
    wire is_susp;
    wire is_resume;
    wire is_chip;
    wire is_array;

    assign proc      = i_clk_en & nv_loaded & ~ack_pending & (req_sync != req_seen);
    assign is_wren   = (link_code == fwp_pkg::CMD_WRITE_ENABLE);
    assign is_wrdi   = (link_code == fwp_pkg::CMD_WRITE_DISABLE);
    assign is_wrsr   = (link_code == fwp_pkg::CMD_WRITE_STATUS);
    assign is_susp   = (link_code == fwp_pkg::CMD_SUSPEND);
    assign is_resume = (link_code == fwp_pkg::CMD_RESUME);
    assign is_chip   = (link_code == fwp_pkg::CMD_ERASE_CHIP_A)
                     | (link_code == fwp_pkg::CMD_ERASE_CHIP_B);
    assign is_array  = is_chip
                     | (link_code == fwp_pkg::CMD_PROGRAM)
                     | (link_code == fwp_pkg::CMD_PROGRAM_QUAD)
                     | (link_code == fwp_pkg::CMD_ERASE_SECTOR)
                     | (link_code == fwp_pkg::CMD_ERASE_32K)
                     | (link_code == fwp_pkg::CMD_ERASE_64K);

    // ****************************************
    // Protected range decode
    // ****************************************
    wire [19:0] blk_size;
    wire [19:0] sec_size;
    wire [19:0] unit_size;
    wire [19:0] addr20;
    wire        range_all;
    wire        range_none;
    wire        in_top;
    wire        in_bot;
    wire        in_range;
    wire        prot_hit;
    wire        any_prot;

    assign blk_size   = (range_code[1:0] == 2'h1) ? fwp_pkg::BLOCK_BYTES :
                        (range_code[1:0] == 2'h2) ? (fwp_pkg::BLOCK_BYTES << 1) :
                                                    (fwp_pkg::BLOCK_BYTES << 2);
    assign sec_size   = range_code[2]             ? fwp_pkg::HALF_BLOCK_BYTES :
                        (range_code[1:0] == 2'h1) ? fwp_pkg::SECTOR_BYTES :
                        (range_code[1:0] == 2'h2) ? (fwp_pkg::SECTOR_BYTES << 1) :
                                                    (fwp_pkg::SECTOR_BYTES << 2);
    assign unit_size  = small_unit_select ? sec_size : blk_size;
    assign range_none = (range_code == fwp_pkg::RANGE_NONE);
    assign range_all  = small_unit_select ? (range_code == fwp_pkg::RANGE_SEC_ALL)
                                          : range_code[2];
    assign addr20     = {1'b0, link_addr[fwp_pkg::ARRAY_AW-1:0]};
    assign in_top     = (addr20 >= (fwp_pkg::ARRAY_BYTES - unit_size));
    assign in_bot     = (addr20 < unit_size);
    assign in_range   = ~range_none & (range_all | (top_bottom_select ? in_bot : in_top));
    // Complement swaps the regions, so one decode serves both tables
    assign prot_hit   = in_range ^ invert_protect;
    assign any_prot   = invert_protect ? ~range_all : ~range_none;

    // ****************************************
    // Status write permission
    // ****************************************
    logic       sreg_allow;
    wire        guard_ok;
    wire        sreg_write;
    wire [15:0] write_word;
    wire [15:0] nv_src;
    wire [1:0]  nv_lock;

    // With four lanes on, the guard pin is a data lane and has no say
    assign guard_ok = four_lane_enable | guard_sync;

    always_comb begin
        unique case (lock_mode)
            fwp_pkg::LOCK_SOFT:  sreg_allow = write_enable_latch;
            fwp_pkg::LOCK_HW:    sreg_allow = write_enable_latch & guard_ok;
            fwp_pkg::LOCK_POWER: sreg_allow = 1'b0;
            fwp_pkg::LOCK_OTP:   sreg_allow = 1'b0;
        endcase
    end

    assign sreg_write = proc & is_wrsr & sreg_allow;
    // One-time bits only ever gain ones
    assign write_word = {1'b0, link_data[fwp_pkg::BIT_CMP],
                         otp_lock_bits | link_data[fwp_pkg::BIT_OTP_LO +: 4],
                         link_data[fwp_pkg::BIT_RANGE_LO +: 8], 2'b00};
    assign nv_src     = nv_loaded ? write_word : i_nv_word;
    assign nv_lock    = nv_src[fwp_pkg::BIT_LOCK_LO +: 2];

    // ****************************************
    // Non-volatile fields
    // ****************************************
    // Stored copy is read once after each power-up; lock-down does not survive it
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            nv_loaded         <= 1'b0;
            range_code        <= fwp_pkg::RANGE_NONE;
            top_bottom_select <= 1'b0;
            small_unit_select <= 1'b0;
            invert_protect    <= 1'b0;
            lock_mode         <= fwp_pkg::LOCK_SOFT;
            four_lane_enable  <= 1'b0;
            otp_lock_bits     <= 4'h0;
        end else if (i_clk_en & (~nv_loaded | sreg_write)) begin
            nv_loaded         <= 1'b1;
            range_code        <= nv_src[fwp_pkg::BIT_RANGE_LO +: 3];
            top_bottom_select <= nv_src[fwp_pkg::BIT_TB];
            small_unit_select <= nv_src[fwp_pkg::BIT_SEC];
            invert_protect    <= nv_src[fwp_pkg::BIT_CMP];
            lock_mode         <= (~nv_loaded & (nv_lock == fwp_pkg::LOCK_POWER))
                               ? fwp_pkg::LOCK_SOFT : nv_lock;
            four_lane_enable  <= nv_src[fwp_pkg::BIT_QE];
            otp_lock_bits     <= nv_src[fwp_pkg::BIT_OTP_LO +: 4];
        end
    end

    // ****************************************
    // Volatile flags
    // ****************************************
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            write_enable_latch <= 1'b0;
        end else if (proc) begin
            if (is_wren) begin
                write_enable_latch <= 1'b1;
            end else if (is_wrdi | is_wrsr | is_array) begin
                write_enable_latch <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            paused_flag <= 1'b0;
        end else if (proc & is_susp) begin
            paused_flag <= 1'b1;
        end else if (proc & is_resume) begin
            paused_flag <= 1'b0;
        end
    end

    // ****************************************
    // Array gate and store requests
    // ****************************************
    wire array_try;
    wire array_block;

    assign array_try   = proc & is_array & write_enable_latch;
    assign array_block = is_chip ? any_prot : prot_hit;

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_array_go     <= 1'b0;
            o_array_refuse <= 1'b0;
            o_sreg_refuse  <= 1'b0;
            o_nv_store     <= 1'b0;
        end else if (i_clk_en) begin
            o_array_go     <= array_try & ~array_block;
            o_array_refuse <= array_try & array_block;
            o_sreg_refuse  <= proc & is_wrsr & ~sreg_allow;
            o_nv_store     <= sreg_write;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_array_addr <= 24'h000000;
            o_array_code <= 8'h00;
        end else if (array_try) begin
            o_array_addr <= link_addr;
            o_array_code <= link_code;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_nv_word <= fwp_pkg::STATUS_RESET;
        end else if (sreg_write) begin
            o_nv_word <= write_word;
        end
    end

    // ****************************************
    // Status snapshot and acknowledge
    // ****************************************
    wire [15:0] status_now;

    assign status_now = {paused_flag, invert_protect, otp_lock_bits, four_lane_enable,
                         lock_mode, small_unit_select, top_bottom_select, range_code,
                         write_enable_latch, i_array_busy};

    // Snapshot one cycle after the update so the host sees the new state
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            req_seen    <= 1'b0;
            ack_pending <= 1'b0;
            ack_tgl     <= 1'b0;
            status_copy <= fwp_pkg::STATUS_RESET;
        end else if (proc) begin
            req_seen    <= req_sync;
            ack_pending <= 1'b1;
        end else if (i_clk_en & ack_pending) begin
            ack_pending <= 1'b0;
            status_copy <= status_now;
            ack_tgl     <= ~ack_tgl;
        end
    end

    assign o_otp_lock         = otp_lock_bits;
    assign o_four_lane_enable = four_lane_enable;
    assign o_guard_pin_enable = ~four_lane_enable;
    assign o_pause_pin_enable = ~four_lane_enable;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb_sys @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);

    sequence s_take(logic [7:0] code);
        proc && (link_code == code);
    endsequence

    sequence s_wrsr(logic [1:0] mode);
        proc && is_wrsr && (lock_mode == mode);
    endsequence

    wel_set_a: assert property (s_take(fwp_pkg::CMD_WRITE_ENABLE) |=> write_enable_latch)
        else $error("enable latch not set");
    wel_clear_a: assert property (proc && (is_wrdi || is_wrsr || is_array)
        |=> !write_enable_latch)
        else $error("enable latch not cleared");
    pause_flag_a: assert property (s_take(fwp_pkg::CMD_SUSPEND) |=> paused_flag ##1
        (paused_flag || $past(proc && is_resume)))
        else $error("paused flag wrong");
    soft_lock_a: assert property (s_wrsr(fwp_pkg::LOCK_SOFT) && write_enable_latch
        |=> o_nv_store && !o_sreg_refuse)
        else $error("soft lock write not accepted");
    hw_lock_a: assert property (s_wrsr(fwp_pkg::LOCK_HW) && !guard_sync && !four_lane_enable
        |=> !o_nv_store && o_sreg_refuse)
        else $error("guarded write not refused");
    hw_open_a: assert property (s_wrsr(fwp_pkg::LOCK_HW) && guard_sync
        |=> o_nv_store == $past(write_enable_latch))
        else $error("unguarded write wrong");
    power_lock_a: assert property (s_wrsr(fwp_pkg::LOCK_POWER)
        |=> !o_nv_store && $stable(range_code) && $stable(lock_mode))
        else $error("power lock write accepted");
    otp_lock_a: assert property (s_wrsr(fwp_pkg::LOCK_OTP) |=> o_sreg_refuse [*1] ##0 !o_nv_store)
        else $error("otp lock write accepted");
    lock_reload_a: assert property (!nv_loaded && i_clk_en
        && (i_nv_word[fwp_pkg::BIT_LOCK_LO +: 2] == fwp_pkg::LOCK_POWER)
        |=> lock_mode == fwp_pkg::LOCK_SOFT)
        else $error("lock-down survived power cycle");
    otp_sticky_a: assert property (nv_loaded && $past(nv_loaded)
        |-> ((otp_lock_bits & $past(otp_lock_bits)) == $past(otp_lock_bits)))
        else $error("one-time bit cleared");
    top_block_a: assert property (!invert_protect && !small_unit_select && !top_bottom_select
        && (range_code == 3'h1) |-> prot_hit == (link_addr[18:0] >= 19'h70000))
        else $error("top block range wrong");
    bottom_block_a: assert property (!invert_protect && !small_unit_select && top_bottom_select
        && (range_code == 3'h2) |-> prot_hit == (link_addr[18:0] <= 19'h1FFFF))
        else $error("bottom block range wrong");
    top_sector_a: assert property (!invert_protect && small_unit_select && !top_bottom_select
        && (range_code == 3'h5) |-> prot_hit == (link_addr[18:0] >= 19'h78000))
        else $error("top sector range wrong");
    bottom_sector_a: assert property (!invert_protect && small_unit_select && top_bottom_select
        && (range_code == 3'h3) |-> prot_hit == (link_addr[18:0] <= 19'h03FFF))
        else $error("bottom sector range wrong");
    fixed_cases_a: assert property (!invert_protect |-> (range_none ? !prot_hit :
        ((small_unit_select ? (range_code == 3'h7) : range_code[2]) ? prot_hit : 1'b1)))
        else $error("fixed range case wrong");
    invert_swap_a: assert property (invert_protect |-> prot_hit == !in_range)
        else $error("complement not applied");
    refuse_prot_a: assert property (array_try && array_block
        |=> o_array_refuse && !o_array_go)
        else $error("protected access not refused");
endmodule

// [rtl/fwp_pkg.sv]
// Constants for the flash array write protection block
// What this block does
// - Top/bottom select 0 protects from array top, 1 from bottom; default 0.
// - Small-unit select 1 uses 4KB sectors, 0 uses 64KB blocks; default 0.
// - Invert-protect bit at S14, default 0, swaps protected and unprotected regions.
// - Lock-mode bits sit at S8 (high) and S7 (low).
// - Lock-mode 00 ignores the guard pin; status write needs only the enable latch.
// - Lock-mode 01 with guard pin low and four-lane enable 0 rejects every status write.
// - Lock-mode 01 with guard pin high accepts status write when latch is set.
// - Lock-mode 10 rejects status writes; a power cycle returns lock-mode to 00.
// - Lock-mode 11 rejects status writes for good.
// - Paused flag S15 set by 75h, cleared by 7Ah and by power cycle.
// - Four one-time lock bits S13..S10, default 0, settable, never clearing.
// - Four-lane enable S9: 0 keeps guard and pause pins, 1 makes data lanes.
// - Block, top: codes 001/010/011 protect from 070000h, 060000h, 040000h upward.
// - Block, bottom: codes 001/010/011 protect zero up to 00FFFFh, 01FFFFh, 03FFFFh.
// - Code 000 protects nothing; block with bit2, or sector 111, protects all.
// - Sector, top: 001/010/011/10x/110 protect top 4KB, 8KB, 16KB, 32KB.
// - Sector, bottom: same codes protect zero up to 000FFFh .. 007FFFh.
// - Range code bits at S4..S2, writable by status write, default 0.
// - Enable latch S1 set by write enable, cleared by disable, program, erase, status write.
package fwp_pkg;
    // ****************************************
    // Array geometry
    // ****************************************
    localparam int          ARRAY_AW         = 19;
    localparam logic [19:0] ARRAY_BYTES      = 20'h80000;
    localparam logic [19:0] BLOCK_BYTES      = 20'h10000;
    localparam logic [19:0] HALF_BLOCK_BYTES = 20'h08000;
    localparam logic [19:0] SECTOR_BYTES     = 20'h01000;

    // ****************************************
    // Status word layout and reset values
    // ****************************************
    localparam int          BIT_BUSY      = 0;
    localparam int          BIT_WEL       = 1;
    localparam int          BIT_RANGE_LO  = 2;
    localparam int          BIT_TB        = 5;
    localparam int          BIT_SEC       = 6;
    localparam int          BIT_LOCK_LO   = 7;
    localparam int          BIT_QE        = 9;
    localparam int          BIT_OTP_LO    = 10;
    localparam int          BIT_CMP       = 14;
    localparam int          BIT_SUS       = 15;
    localparam logic [15:0] STATUS_RESET  = 16'h0000;
    localparam logic [2:0]  RANGE_NONE    = 3'h0;
    localparam logic [2:0]  RANGE_SEC_ALL = 3'h7;

    // ****************************************
    // Lock modes
    // ****************************************
    localparam logic [1:0] LOCK_SOFT  = 2'h0;
    localparam logic [1:0] LOCK_HW    = 2'h1;
    localparam logic [1:0] LOCK_POWER = 2'h2;
    localparam logic [1:0] LOCK_OTP   = 2'h3;

    // ****************************************
    // Instruction codes
    // ****************************************
    localparam logic [7:0] CMD_WRITE_ENABLE  = 8'h06;
    localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] CMD_WRITE_STATUS  = 8'h01;
    localparam logic [7:0] CMD_PROGRAM       = 8'h02;
    localparam logic [7:0] CMD_PROGRAM_QUAD  = 8'h32;
    localparam logic [7:0] CMD_ERASE_SECTOR  = 8'h20;
    localparam logic [7:0] CMD_ERASE_32K     = 8'h52;
    localparam logic [7:0] CMD_ERASE_64K     = 8'hD8;
    localparam logic [7:0] CMD_ERASE_CHIP_A  = 8'hC7;
    localparam logic [7:0] CMD_ERASE_CHIP_B  = 8'h60;
    localparam logic [7:0] CMD_SUSPEND       = 8'h75;
    localparam logic [7:0] CMD_RESUME        = 8'h7A;
endpackage

// [tb/spi_host_model.sv]
// Host model issuing one flash instruction at a time over the link
`timescale 1ns/1ps
module spi_host_model (
    output logic        o_spi_clk,
    output logic        o_cmd_valid,
    output logic [47:0] o_cmd,
    input  wire logic   i_cmd_ready
);
    initial {o_spi_clk, o_cmd_valid, o_cmd} = '0;
    // Link clock only runs while a command is outstanding
    task automatic tick;
        #6 o_spi_clk = 1'b1;
        #6 o_spi_clk = 1'b0;
    endtask
    task automatic send(input logic [47:0] c);
        int n;
        o_cmd = c;
        o_cmd_valid = 1'b1;
        tick();
        o_cmd_valid = 1'b0;
        // Released lines show inverted data so a stale value cannot pass
        o_cmd = ~c;
        n = 0;
        while (i_cmd_ready !== 1'b1 && n < 40) begin
            tick();
            n++;
        end
    endtask
endmodule

// [tb/test_flash_array_write_protect.sv]
// Self-checking bench for the flash array write protection block
`timescale 1ns/1ps
module test_flash_array_write_protect;
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic        guard   = 1'b1;
    logic [15:0] nv      = 16'h0000;
    logic        spi_clk, valid, ready, go, refuse, sref, store, four, gpe, ppe, p, q;
    logic [23:0] aadr;
    logic [7:0]  acode, pc;
    logic        go_seen, ref_seen, sr_seen;
    logic [47:0] cmd_bus;
    logic [15:0] status, nv_out, w;
    logic [3:0]  otp;
    logic [18:0] a;
    int          mismatches = 0;
    int          cmp_count  = 0;
    int          i;
    logic [18:0] edges [13] = '{19'h70000, 19'h6FFFF, 19'h60000, 19'h40000, 19'h3FFFF,
        19'h0FFFF, 19'h10000, 19'h7F000, 19'h7EFFF, 19'h07FFF, 19'h08000, 19'h00FFF, 19'h01000};

    spi_host_model host (.o_spi_clk(spi_clk), .o_cmd_valid(valid), .o_cmd(cmd_bus),
        .i_cmd_ready(ready));
    flash_array_write_protect DUT (
        .i_clk_sys(clk_sys), .i_sys_rst(sys_rst), .i_clk_en(1'b1), .i_spi_clk(spi_clk),
        .i_cmd_valid(valid), .i_cmd_code(cmd_bus[47:40]), .i_cmd_addr(cmd_bus[39:16]),
        .i_cmd_data(cmd_bus[15:0]), .i_write_guard(guard), .i_array_busy(1'b0),
        .i_nv_word(nv), .o_cmd_ready(ready), .o_status_word(status), .o_array_go(go),
        .o_array_refuse(refuse), .o_array_addr(aadr), .o_array_code(acode),
        .o_sreg_refuse(sref), .o_nv_store(store), .o_nv_word(nv_out), .o_otp_lock(otp),
        .o_four_lane_enable(four), .o_guard_pin_enable(gpe), .o_pause_pin_enable(ppe));

    always #20 clk_sys = ~clk_sys;
    // Pulses are caught here; nv stands in for the non-volatile cells
    always @(posedge clk_sys) begin
        go_seen  <= go_seen | go;
        ref_seen <= ref_seen | refuse;
        sr_seen  <= sr_seen | sref;
        if (store === 1'b1) nv <= nv_out;
    end

    function automatic logic prot(input logic [15:0] wd, input logic [18:0] ad);
        logic [19:0] sz;
        if (wd[4:2] == 3'h0) sz = 20'h0;
        else if (wd[6]) sz = (wd[4:2] == 3'h7) ? 20'h80000 : 20'h00800 << (wd[4] ? 3'h4 : wd[4:2]);
        else sz = wd[4] ? 20'h80000 : 20'h08000 << wd[4:2];
        return wd[14] ^ (sz != 0 && (wd[5] ? {1'b0, ad} < sz : {1'b0, ad} >= 20'h80000 - sz));
    endfunction
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] c, input logic [23:0] ad, input logic [15:0] d);
        {go_seen, ref_seen, sr_seen} = 3'b000;
        host.send({c, ad, d});
        // Pulses land one sys cycle before the snapshot, so they are caught before this wait
        repeat (2) @(negedge clk_sys);
    endtask
    task automatic wrsr(input logic [15:0] d);
        cmd(8'h06, 24'h0, 16'h0);
        cmd(8'h01, 24'h0, d);
    endtask
    task automatic pwr(input logic [15:0] word, input logic g);
        @(negedge clk_sys);
        nv <= word;
        guard <= g;
        sys_rst <= 1'b1;
        repeat (3) @(negedge clk_sys);
        sys_rst <= 1'b0;
        @(negedge clk_sys);
    endtask
    task automatic conclude;
        $display("compares=%0d mismatches=%0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        void'($urandom(22));
        pwr(16'h0000, 1'b1);
        cmd(8'h01, 24'h0, 16'h0010);
        chk(status, 16'h0000);
        for (i = 0; i < 8; i++) begin
            pwr({7'h0, i[2:1], 7'h0}, i[0]);
            w = (i[2:1] == 2'h2) ? 16'h0000 : {7'h0, i[2:1], 7'h0};
            wrsr(w | 16'h0010);
            p = (w[8:7] == 2'h0) || (w[8:7] == 2'h1 && i[0]);
            chk(status, p ? (w | 16'h0010) : w);
            chk(sr_seen, !p);
        end
        pwr(16'h0000, 1'b1);
        wrsr(16'h0100);
        wrsr(16'h0014);
        chk(status, 16'h0100);
        pwr(nv, 1'b1);
        cmd(8'h05, 24'h0, 16'h0);
        chk(status, 16'h0000);
        $display("lock mode test done");
        wrsr(16'h0400);
        // Guard pin is driven, never tied to a rail, so four lanes may be set
        wrsr(16'h0A00);
        chk({otp, four, gpe, ppe}, 24'h00001C);
        wrsr(16'h0000);
        chk(status, 16'h0C00);
        cmd(8'h75, 24'h0, 16'h0);
        chk(status, 16'h8C00);
        cmd(8'h7A, 24'h0, 16'h0);
        chk(status, 16'h0C00);
        cmd(8'h75, 24'h0, 16'h0);
        pwr(nv, 1'b1);
        cmd(8'h05, 24'h0, 16'h0);
        chk(status, 16'h0C00);
        $display("one-time and pause test done");
        pwr(16'h0000, 1'b1);
        for (i = 0; i < 48; i++) begin
            w = 16'($urandom) & 16'h407C;
            a = ($urandom % 2) ? edges[$urandom % 13] : 19'($urandom);
            wrsr(w);
            if (i % 6 != 0) cmd(8'h06, 24'h0, 16'h0);
            pc = ($urandom % 2) ? 8'h32 : 8'h02;
            cmd(pc, {5'h0, a}, 16'h0);
            if (i % 6 != 0) begin
                chk(aadr, {5'h0, a});
                chk(acode, pc);
            end
            p = prot(w, a) && (i % 6 != 0);
            q = !prot(w, a) && (i % 6 != 0);
            chk({ref_seen, go_seen}, {p, q});
            chk(status, w);
        end
        $display("range decode test done");
        conclude();
    end
    initial begin
        #400000;
        mismatches++;
        conclude();
    end
endmodule
